// ### testbench.sv
`timescale 1ns/1ps
module testbench;
    // ================
    // Signals
    reg core_clk = 1'b0;
    reg srst = 1'b1;
    reg operating_enable_bit = 1'b0;
    reg smp_valid = 1'b0;
    reg [23:0] smp_xyz = 24'h0;
    reg [23:0] hpf_xyz = 24'h0;
    wire scl, sda_drv, sda_oe, sda_out, self_test_en;
    wire single_tap_r, double_tap_r, tap_int_r, motion_active_r, rotate_allowed_r;
    wire [7:0] angle_limit;
    wire sda_line = sda_drv & ~sda_oe;
    integer fails = 0;
    integer tests_run = 0;
    integer n_s = 0;
    integer n_d = 0;
    integer i;
    reg [7:0] q;
    reg nak;
    localparam [6:0] DEV = 7'h0F;
    localparam [63:0] OFS = {8'h2C, 8'h2D, 8'h2E, 8'h2F, 8'h30, 8'h31, 8'h5A, 8'h5C};
    localparam [63:0] RST = {8'hB6, 8'h1A, 8'hA2, 8'h24, 8'h28, 8'hA0, 8'h08, 8'h0C};
    initial forever #10 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        if (single_tap_r === 1'b1) n_s = n_s + 1;
        if (double_tap_r === 1'b1) n_d = n_d + 1;
    end
    tmt_tap_cfg DUT (.core_clk(core_clk), .srst(srst), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .operating_enable_bit(operating_enable_bit),
        .smp_valid(smp_valid), .smp_xyz(smp_xyz), .hpf_xyz(hpf_xyz),
        .single_tap_r(single_tap_r), .double_tap_r(double_tap_r), .tap_int_r(tap_int_r),
        .motion_active_r(motion_active_r), .rotate_allowed_r(rotate_allowed_r),
        .self_test_en(self_test_en), .angle_limit(angle_limit));
    tmt_host_model host (.core_clk(core_clk), .sda_line(sda_line), .scl(scl),
        .sda_drv(sda_drv));
    // ================
    // Shared tasks
    task print_verdict;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task chk(input [63:0] nm, input [7:0] e, input [7:0] g);
        tests_run = tests_run + 1;
        if (g !== e)
        begin
            fails = fails + 1;
            $display("BAD %0s expected %h seen %h", nm, e, g);
        end
    endtask
    // Engine is held idle while disabled, so writes also restart it
    task cfg(input [7:0] ra, input [7:0] d);
        operating_enable_bit = 1'b0;
        host.wr(DEV, ra, d, nak);
        chk("wr_ack", 8'h00, {7'h0, nak});
        operating_enable_bit = 1'b1;
    endtask
    task rdchk(input [7:0] ra, input [7:0] e);
        host.rd(DEV, ra, q);
        chk("rd_data", e, q);
    endtask
    task smp(input [23:0] s);
        smp_valid = 1'b1;
        smp_xyz = s;
        @(negedge core_clk);
        smp_valid = 1'b0;
        repeat (5) @(negedge core_clk);
    endtask
    task idle(input integer n);
        repeat (n) smp(24'h0);
    endtask
    task tap(input [23:0] a, input [23:0] b, input integer g, input [7:0] es, input [7:0] ed);
        n_s = 0;
        n_d = 0;
        idle(1);
        smp(a);
        idle(g);
        smp(b);
        idle(24);
        chk("n_single", es, n_s[7:0]);
        chk("n_double", ed, n_d[7:0]);
    endtask
    // ================
    // Scenarios
    task test_regs;
        for (i = 0; i < 8; i = i + 1)
            rdchk(OFS[63-8*i -: 8], RST[63-8*i -: 8]);
        rdchk(8'h3A, 8'h00);
        rdchk(8'h40, 8'h00);
        chk("angle", 8'h0C, angle_limit);
        chk("selftest", 8'h00, {7'h0, self_test_en});
        $display("test regs done");
    endtask
    task test_selftest;
        cfg(8'h3A, 8'hCA);
        chk("selftest", 8'h01, {7'h0, self_test_en});
        cfg(8'h3A, 8'h00);
        chk("selftest", 8'h00, {7'h0, self_test_en});
        host.wr(7'h10, 8'h2C, 8'h00, nak);
        chk("bad_addr", 8'h01, {7'h0, nak});
        rdchk(8'h2C, 8'hB6);
        cfg(8'h5C, 8'h06);
        chk("angle", 8'h06, angle_limit);
        rdchk(8'h5C, 8'h06);
        $display("test selftest done");
    endtask
    task test_single;
        cfg(8'h31, 8'h10);
        n_s = 0;
        idle(1);
        smp(24'h0AF60A);
        idle(7);
        chk("early", 8'h00, n_s[7:0]);
        idle(20);
        chk("n_single", 8'h01, n_s[7:0]);
        chk("n_double", 8'h00, n_d[7:0]);
        $display("test single done");
    endtask
    task test_band;
        cfg(8'h2C, 8'h10);
        cfg(8'h2D, 8'h9A);
        tap(24'h0A0B0B, 24'h0, 0, 8'h01, 8'h00);
        tap(24'h0D0D0E, 24'h0, 0, 8'h00, 8'h00);
        tap(24'h080909, 24'h0, 0, 8'h00, 8'h00);
        tap(24'h0A0A0A, 24'h0A0A0A, 0, 8'h00, 8'h00);
        $display("test band done");
    endtask
    task test_double;
        tap(24'h0A0A0A, 24'h0A0A0A, 3, 8'h00, 8'h01);
        cfg(8'h2F, 8'h02);
        tap(24'h0A0A0A, 24'h0A0A0A, 3, 8'h01, 8'h00);
        $display("test double done");
    endtask
    task test_motion;
        hpf_xyz = 24'h000009;
        smp(24'h0);
        chk("motion", 8'h01, {7'h0, motion_active_r});
        hpf_xyz = 24'h000008;
        smp(24'h0);
        chk("motion", 8'h00, {7'h0, motion_active_r});
        hpf_xyz = 24'hF70000;
        smp(24'h0);
        chk("motion", 8'h01, {7'h0, motion_active_r});
        smp(24'h000007);
        chk("rotate", 8'h01, {7'h0, rotate_allowed_r});
        smp(24'h000006);
        chk("rotate", 8'h00, {7'h0, rotate_allowed_r});
        operating_enable_bit = 1'b0;
        repeat (2) @(negedge core_clk);
        chk("motion", 8'h00, {7'h0, motion_active_r});
        operating_enable_bit = 1'b1;
        $display("test motion done");
    endtask
    // ================
    // Main sequence and watchdog
    initial
    begin
        repeat (4) @(negedge core_clk);
        srst = 1'b0;
        repeat (3) @(negedge core_clk);
        test_regs;
        test_selftest;
        test_single;
        test_band;
        test_double;
        test_motion;
        print_verdict;
    end
    initial
    begin
        repeat (100000) @(posedge core_clk);
        fails = fails + 1;
        print_verdict;
    end
endmodule // testbench
bind tmt_tap_cfg tmt_tap_cfg_assertions u_chk (.core_clk(core_clk), .srst(srst),
    .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .operating_enable_bit(operating_enable_bit), .smp_valid(smp_valid),
    .single_tap_r(single_tap_r), .double_tap_r(double_tap_r), .tap_int_r(tap_int_r),
    .motion_active_r(motion_active_r), .rotate_allowed_r(rotate_allowed_r));

// ### tmt_host_model.sv
`timescale 1ns/1ps
module tmt_host_model (
    // Clock
    input wire core_clk,
    // Bus wires
    input wire sda_line,
    output reg scl,
    output reg sda_drv
);
    initial
    begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // ================
    // Bit level; data moves only well after scl falls
    task hw(input integer n);
        repeat (n) @(negedge core_clk);
    endtask
    task bitx(input b, output r);
        hw(3);
        sda_drv = b;
        hw(8);
        scl = 1'b1;
        hw(8);
        r = sda_line;
        scl = 1'b0;
    endtask
    task bytex(input [7:0] d, input last, output [7:0] q, output ack);
        integer i;
        for (i = 7; i >= 0; i = i - 1)
            bitx(d[i], q[i]);
        bitx(last, ack);
    endtask
    task start;
        hw(3);
        sda_drv = 1'b1;
        hw(3);
        scl = 1'b1;
        hw(8);
        sda_drv = 1'b0;
        hw(8);
        scl = 1'b0;
    endtask
    task stop;
        hw(3);
        sda_drv = 1'b0;
        hw(8);
        scl = 1'b1;
        hw(8);
        sda_drv = 1'b1;
        hw(8);
    endtask
    // ================
    // Register transfers
    task wr(input [6:0] dev, input [7:0] ra, input [7:0] d, output nak);
        reg [7:0] q;
        reg a0, a1, a2;
        start;
        bytex({dev, 1'b0}, 1'b1, q, a0);
        bytex(ra, 1'b1, q, a1);
        bytex(d, 1'b1, q, a2);
        stop;
        nak = a0 | a1 | a2;
    endtask
    task rd(input [6:0] dev, input [7:0] ra, output [7:0] d);
        reg [7:0] q;
        reg a;
        start;
        bytex({dev, 1'b0}, 1'b1, q, a);
        bytex(ra, 1'b1, q, a);
        start;
        bytex({dev, 1'b1}, 1'b1, q, a);
        // Master NACK ends the read
        bytex(8'hFF, 1'b1, d, a);
        stop;
    endtask
endmodule // tmt_host_model

// ### tmt_i2c_slave.v
`timescale 1ns/1ps
module tmt_i2c_slave #(
    parameter [6:0] DEV_ADDR = 7'h0F
) (
    // Clock and reset
    input wire core_clk,
    input wire srst,
    // Bus pins
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe,
    // Register port
    output reg [7:0] reg_addr_r,
    output reg [7:0] wr_data_r,
    output reg wr_stb_r,
    input wire [7:0] rd_data
);
    // ================
    // Pin synchronisers
    reg [1:0] scl_s_r;
    reg [1:0] sda_s_r;
    reg scl_d_r;
    reg sda_d_r;
    wire scl_rise = scl_s_r[1] & ~scl_d_r;
    wire scl_fall = ~scl_s_r[1] & scl_d_r;
    wire start_c = scl_s_r[1] & scl_d_r & sda_d_r & ~sda_s_r[1];
    wire stop_c = scl_s_r[1] & scl_d_r & ~sda_d_r & sda_s_r[1];
    // ================
    // Byte engine
    localparam [2:0] PH_IDLE = 3'h0;
    localparam [2:0] PH_ADDR = 3'h1;
    localparam [2:0] PH_REG = 3'h2;
    localparam [2:0] PH_WR = 3'h3;
    localparam [2:0] PH_RD = 3'h4;
    reg [2:0] phase_r;
    reg [3:0] bitc_r;
    reg [7:0] shift_r;
    reg [7:0] tx_r;
    reg ack_r;
    reg mslot_r;
    reg nack_r;
    assign sda_out = 1'b0;
    assign sda_oe = ack_r | (phase_r == PH_RD && !mslot_r && !tx_r[7]);
    always @(posedge core_clk)
    begin
        if (srst)
        begin
            scl_s_r <= 2'h3;
            sda_s_r <= 2'h3;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
            phase_r <= PH_IDLE;
            bitc_r <= 4'h0;
            shift_r <= 8'h00;
            tx_r <= 8'hFF;
            ack_r <= 1'b0;
            mslot_r <= 1'b0;
            nack_r <= 1'b0;
            reg_addr_r <= 8'h00;
            wr_data_r <= 8'h00;
            wr_stb_r <= 1'b0;
        end
        else
        begin
            scl_s_r <= {scl_s_r[0], scl_in};
            sda_s_r <= {sda_s_r[0], sda_in};
            scl_d_r <= scl_s_r[1];
            sda_d_r <= sda_s_r[1];
            wr_stb_r <= 1'b0;
            if (start_c)
            begin
                phase_r <= PH_ADDR;
                bitc_r <= 4'h0;
                ack_r <= 1'b0;
                mslot_r <= 1'b0;
            end
            else if (stop_c)
            begin
                phase_r <= PH_IDLE;
                ack_r <= 1'b0;
                mslot_r <= 1'b0;
            end
            else if (scl_rise && phase_r != PH_IDLE)
            begin
                if (mslot_r)
                    nack_r <= sda_s_r[1];
                else if (!ack_r)
                begin
                    shift_r <= {shift_r[6:0], sda_s_r[1]};
                    bitc_r <= bitc_r + 4'h1;
                end
            end
            else if (scl_fall && phase_r != PH_IDLE)
            begin
                if (ack_r)
                begin
                    // Read data is fetched as the address ack ends
                    ack_r <= 1'b0;
                    bitc_r <= 4'h0;
                    if (phase_r == PH_RD)
                    begin
                        tx_r <= rd_data;
                        reg_addr_r <= reg_addr_r + 8'h01;
                    end
                end
                else if (mslot_r)
                begin
                    mslot_r <= 1'b0;
                    bitc_r <= 4'h0;
                    if (nack_r)
                        phase_r <= PH_IDLE;
                    else
                    begin
                        tx_r <= rd_data;
                        reg_addr_r <= reg_addr_r + 8'h01;
                    end
                end
                else if (phase_r == PH_RD)
                begin
                    tx_r <= {tx_r[6:0], 1'b1};
                    if (bitc_r == 4'h8)
                        mslot_r <= 1'b1;
                end
                else if (bitc_r == 4'h8)
                begin
                    case (phase_r)
                        PH_ADDR:
                        begin
                            if (shift_r[7:1] == DEV_ADDR)
                            begin
                                ack_r <= 1'b1;
                                phase_r <= shift_r[0] ? PH_RD : PH_REG;
                            end
                            else
                                phase_r <= PH_IDLE;
                        end
                        PH_REG:
                        begin
                            reg_addr_r <= shift_r;
                            ack_r <= 1'b1;
                            phase_r <= PH_WR;
                        end
                        PH_WR:
                        begin
                            wr_data_r <= shift_r;
                            wr_stb_r <= 1'b1;
                            ack_r <= 1'b1;
                        end
                        default:
                            phase_r <= PH_IDLE;
                    endcase
                end
            end
            // Address advances one cycle after the strobe carries it
            if (wr_stb_r)
                reg_addr_r <= reg_addr_r + 8'h01;
        end
    end
endmodule // tmt_i2c_slave

// ### tmt_jerk_calc.v
`timescale 1ns/1ps
module tmt_jerk_calc #(
    parameter SW = 8
) (
    // Clock and reset
    input wire core_clk,
    input wire srst,
    // Sample input
    input wire smp_valid,
    input wire [3*SW-1:0] smp_xyz,
    // Jerk index output
    output reg [SW+1:0] jerk_index_r,
    output reg jerk_valid_r
);
    // ================
    // Per-axis absolute difference
    reg [3*SW-1:0] prev_r;
    reg prev_ok_r;
    wire [3*SW-1:0] adiff;
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : g_axis
            wire signed [SW:0] d = $signed({smp_xyz[g*SW+SW-1], smp_xyz[g*SW +: SW]})
                - $signed({prev_r[g*SW+SW-1], prev_r[g*SW +: SW]});
            wire [SW:0] m = d[SW] ? (~d + {{SW{1'b0}}, 1'b1}) : d;
            // Saturate: a full-scale swing exceeds any 7-bit low limit anyway
            assign adiff[g*SW +: SW] = m[SW] ? {SW{1'b1}} : m[SW-1:0];
        end
    endgenerate
    wire [SW+1:0] jsum = {2'b00, adiff[SW-1:0]} + {2'b00, adiff[2*SW-1:SW]}
        + {2'b00, adiff[3*SW-1:2*SW]};
    always @(posedge core_clk)
    begin
        if (srst)
        begin
            prev_r <= {3*SW{1'b0}};
            prev_ok_r <= 1'b0;
            jerk_index_r <= {(SW+2){1'b0}};
            jerk_valid_r <= 1'b0;
        end
        else
        begin
            jerk_valid_r <= smp_valid & prev_ok_r;
            if (smp_valid)
            begin
                prev_r <= smp_xyz;
                prev_ok_r <= 1'b1;
                jerk_index_r <= jsum;
            end
        end
    end
endmodule // tmt_jerk_calc

// ### tmt_regs.vh
`ifndef TMT_REGS_VH
`define TMT_REGS_VH
// ================
// Register offsets
`define TMT_OFS_JERK_HI 8'h2C
`define TMT_OFS_JERK_LO 8'h2D
`define TMT_OFS_DUR 8'h2E
`define TMT_OFS_TOTAL 8'h2F
`define TMT_OFS_LAT 8'h30
`define TMT_OFS_WIN 8'h31
`define TMT_OFS_SELFTEST 8'h3A
`define TMT_OFS_MOTION 8'h5A
`define TMT_OFS_ANGLE 8'h5C
`define TMT_OFS_STATUS 8'h7E
// ================
// Reset values
`define TMT_RST_JERK_HI 8'hB6
`define TMT_RST_JERK_LO 8'h1A
`define TMT_RST_DUR 8'hA2
`define TMT_RST_TOTAL 8'h24
`define TMT_RST_LAT 8'h28
`define TMT_RST_WIN 8'hA0
`define TMT_RST_MOTION 8'h08
`define TMT_RST_ANGLE 8'h0C
// ================
// Field positions
`define TMT_HI_LSB_BIT 7
`define TMT_LO_MSB 6
`define TMT_DUR_MIN_MSB 2
`define TMT_DUR_MAX_LSB 3
`define TMT_DUR_MAX_MSB 7
// ================
// Self-test keys
`define TMT_SELFTEST_KEY 8'hCA
`define TMT_SELFTEST_OFF 8'h00
`endif

// ### tmt_tap_cfg.v
// Summary of operation
// - Nine-bit high limit split across two registers
// - Jerk index sums absolute axis differences
// - Tap counts only between low and high
// - Tap counters tick once per sample period
// - Tap run length within min and max
// - Double tap total bounded by total time
// - Above-threshold counting capped at latency value
// - Whole tap event completes within window
// - Single tap reported after window expires
// - Tap registers reset to recommended defaults
// - 0xCA enables self-test, 0x00 disables
// - Motion threshold register, reset 0x08
// - Tilt angle threshold register, reset 0x0C
// - Samples at or above high limit are discarded
// - Motion when filtered axis exceeds threshold
// - Motion threshold scaled 16 counts per g

`timescale 1ns/1ps
`include "tmt_regs.vh"

module tmt_tap_cfg #(
    parameter SW = 8,
    parameter [6:0] DEV_ADDR = 7'h0F
) (
    // Clock and reset
    input wire core_clk,
    input wire srst,
    // Serial register bus
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe,
    // Operating enable from the main control register
    input wire operating_enable_bit,
    // Acceleration samples, signed, one set per sample period
    input wire smp_valid,
    input wire [3*SW-1:0] smp_xyz,
    input wire [3*SW-1:0] hpf_xyz,
    // Detector outputs
    output reg single_tap_r,
    output reg double_tap_r,
    output reg tap_int_r,
    output reg motion_active_r,
    output reg rotate_allowed_r,
    output wire self_test_en,
    output wire [7:0] angle_limit
);

    // ================
    // Register file
    wire [7:0] reg_addr;
    wire [7:0] wr_data;
    wire wr_stb;
    reg [7:0] rd_data;
    reg [7:0] jerk_hi_r;
    reg [7:0] jerk_lo_r;
    reg [7:0] dur_r;
    reg [7:0] total_r;
    reg [7:0] lat_r;
    reg [7:0] win_r;
    reg [7:0] motion_thr_r;
    reg [7:0] angle_r;
    reg [7:0] selftest_r;
    reg last_single_r;
    reg last_double_r;
    wire tap_busy;

    tmt_i2c_slave #(
        .DEV_ADDR(DEV_ADDR)
    ) u_bus (
        .core_clk(core_clk),
        .srst(srst),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .reg_addr_r(reg_addr),
        .wr_data_r(wr_data),
        .wr_stb_r(wr_stb),
        .rd_data(rd_data)
    );

    // Writes land whatever the enable; the engine idles while it is low,
    // so new limits take effect cleanly from the next enable
    always @(posedge core_clk)
    begin
        if (srst)
        begin
            jerk_hi_r <= `TMT_RST_JERK_HI;
            jerk_lo_r <= `TMT_RST_JERK_LO;
            dur_r <= `TMT_RST_DUR;
            total_r <= `TMT_RST_TOTAL;
            lat_r <= `TMT_RST_LAT;
            win_r <= `TMT_RST_WIN;
            motion_thr_r <= `TMT_RST_MOTION;
            angle_r <= `TMT_RST_ANGLE;
            selftest_r <= `TMT_SELFTEST_OFF;
        end
        else if (wr_stb)
        begin
            case (reg_addr)
                `TMT_OFS_JERK_HI: jerk_hi_r <= wr_data;
                `TMT_OFS_JERK_LO: jerk_lo_r <= wr_data;
                `TMT_OFS_DUR: dur_r <= wr_data;
                `TMT_OFS_TOTAL: total_r <= wr_data;
                `TMT_OFS_LAT: lat_r <= wr_data;
                `TMT_OFS_WIN: win_r <= wr_data;
                `TMT_OFS_SELFTEST: selftest_r <= wr_data;
                `TMT_OFS_MOTION: motion_thr_r <= wr_data;
                `TMT_OFS_ANGLE: angle_r <= wr_data;
                default: ;
            endcase
        end
    end

    // Self-test register is write-only and reads as zero
    always @*
    begin
        case (reg_addr)
            `TMT_OFS_JERK_HI: rd_data = jerk_hi_r;
            `TMT_OFS_JERK_LO: rd_data = jerk_lo_r;
            `TMT_OFS_DUR: rd_data = dur_r;
            `TMT_OFS_TOTAL: rd_data = total_r;
            `TMT_OFS_LAT: rd_data = lat_r;
            `TMT_OFS_WIN: rd_data = win_r;
            `TMT_OFS_MOTION: rd_data = motion_thr_r;
            `TMT_OFS_ANGLE: rd_data = angle_r;
            `TMT_OFS_STATUS: rd_data = {3'h0, rotate_allowed_r, motion_active_r,
                tap_busy, last_double_r, last_single_r};
            default: rd_data = 8'h00;
        endcase
    end

    // Any value other than the key leaves self-test off
    assign self_test_en = (selftest_r == `TMT_SELFTEST_KEY);
    assign angle_limit = angle_r;

    // ================
    // Thresholds and bounds
    wire [8:0] high_limit = {jerk_hi_r, jerk_lo_r[`TMT_HI_LSB_BIT]};
    wire [6:0] low_limit = jerk_lo_r[`TMT_LO_MSB:0];
    wire [2:0] tap_min_count = dur_r[`TMT_DUR_MIN_MSB:0];
    wire [4:0] tap_max_count = dur_r[`TMT_DUR_MAX_MSB:`TMT_DUR_MAX_LSB];

    wire [SW+1:0] jerk_index;
    wire jerk_valid;
    tmt_jerk_calc #(
        .SW(SW)
    ) u_jerk (
        .core_clk(core_clk),
        .srst(srst),
        .smp_valid(smp_valid),
        .smp_xyz(smp_xyz),
        .jerk_index_r(jerk_index),
        .jerk_valid_r(jerk_valid)
    );

    wire [SW+2:0] ji = {1'b0, jerk_index};
    wire over_high = ji >= {{(SW-6){1'b0}}, high_limit};
    wire above_low = ji > {{(SW-4){1'b0}}, low_limit};
    wire in_band = above_low & ~over_high;
    wire below_low = ~above_low;

    // ================
    // Tap qualifier
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_FIRST = 3'h1;
    localparam [2:0] ST_GAP = 3'h2;
    localparam [2:0] ST_SECOND = 3'h3;
    localparam [2:0] ST_TRAIL = 3'h4;

    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg [7:0] win_cnt_r;
    reg [7:0] run_cnt_r;
    reg [7:0] tot_cnt_r;
    reg [7:0] lat_cnt_r;
    assign tap_busy = (state_r != ST_IDLE);
    wire [7:0] win_inc = (win_cnt_r == 8'hFF) ? win_cnt_r : win_cnt_r + 8'h01;
    wire win_done = (win_inc >= win_r);
    wire can_count = (lat_cnt_r < lat_r);
    wire run_ok = (run_cnt_r >= {5'h00, tap_min_count})
        && (run_cnt_r <= {3'h0, tap_max_count});
    wire tot_ok = (tot_cnt_r <= total_r);
    reg fire_single;
    reg fire_double;

    always @*
    begin
        state_nxt = state_r;
        fire_single = 1'b0;
        fire_double = 1'b0;
        case (state_r)
            ST_IDLE:
                if (in_band)
                    state_nxt = ST_FIRST;
            ST_FIRST:
                if (win_done)
                    state_nxt = ST_IDLE;
                else if (below_low)
                    state_nxt = run_ok ? ST_GAP : ST_IDLE;
            ST_GAP:
                if (win_done)
                begin
                    fire_single = 1'b1;
                    state_nxt = ST_IDLE;
                end
                else if (in_band)
                    state_nxt = ST_SECOND;
            ST_SECOND:
                if (below_low && run_ok && tot_ok)
                begin
                    fire_double = 1'b1;
                    state_nxt = ST_IDLE;
                end
                else if (win_done)
                begin
                    fire_single = 1'b1;
                    state_nxt = ST_IDLE;
                end
                else if (below_low)
                    state_nxt = ST_TRAIL;
            ST_TRAIL:
                if (win_done)
                begin
                    fire_single = 1'b1;
                    state_nxt = ST_IDLE;
                end
            default:
                state_nxt = ST_IDLE;
        endcase
    end

    always @(posedge core_clk)
    begin
        if (srst || !operating_enable_bit)
        begin
            state_r <= ST_IDLE;
            win_cnt_r <= 8'h00;
            run_cnt_r <= 8'h00;
            tot_cnt_r <= 8'h00;
            lat_cnt_r <= 8'h00;
            single_tap_r <= 1'b0;
            double_tap_r <= 1'b0;
            tap_int_r <= 1'b0;
        end
        else
        begin
            single_tap_r <= 1'b0;
            double_tap_r <= 1'b0;
            tap_int_r <= 1'b0;
            // One step per new sample set, in sample periods
            if (jerk_valid)
            begin
                state_r <= state_nxt;
                single_tap_r <= fire_single;
                double_tap_r <= fire_double;
                tap_int_r <= fire_single | fire_double;
                win_cnt_r <= win_inc;
                if (state_r == ST_IDLE)
                begin
                    // Fresh candidate event
                    win_cnt_r <= 8'h01;
                    run_cnt_r <= 8'h01;
                    tot_cnt_r <= 8'h01;
                    lat_cnt_r <= 8'h01;
                end
                else if (state_r == ST_GAP && in_band)
                begin
                    run_cnt_r <= 8'h01;
                    lat_cnt_r <= 8'h01;
                    tot_cnt_r <= tot_cnt_r + {7'h00, tot_cnt_r != 8'hFF};
                end
                else if ((state_r == ST_FIRST || state_r == ST_SECOND)
                    && in_band && can_count)
                begin
                    run_cnt_r <= run_cnt_r + {7'h00, run_cnt_r != 8'hFF};
                    tot_cnt_r <= tot_cnt_r + {7'h00, tot_cnt_r != 8'hFF};
                    lat_cnt_r <= lat_cnt_r + 8'h01;
                end
            end
        end
    end

    // ================
    // Tap result status, held until the next result
    always @(posedge core_clk)
    begin
        if (srst)
        begin
            last_single_r <= 1'b0;
            last_double_r <= 1'b0;
        end
        else if (single_tap_r | double_tap_r)
        begin
            last_single_r <= single_tap_r;
            last_double_r <= double_tap_r;
        end
    end

    // ================
    // Motion and tilt compare, both in the sample domain
    reg [2:0] mot_hit;
    reg [1:0] tilt_hit;
    integer i;
    reg [SW-1:0] a;

    always @*
    begin
        mot_hit = 3'h0;
        tilt_hit = 2'h0;
        a = {SW{1'b0}};
        for (i = 0; i < 3; i = i + 1)
        begin
            a = hpf_xyz[i*SW+SW-1] ? (~hpf_xyz[i*SW +: SW] + {{(SW-1){1'b0}}, 1'b1})
                : hpf_xyz[i*SW +: SW];
            // Filtered data arrives at 16 counts per g
            mot_hit[i] = (a > motion_thr_r);
        end
        for (i = 0; i < 2; i = i + 1)
        begin
            a = smp_xyz[i*SW+SW-1] ? (~smp_xyz[i*SW +: SW] + {{(SW-1){1'b0}}, 1'b1})
                : smp_xyz[i*SW +: SW];
            tilt_hit[i] = (a > angle_r);
        end
    end

    always @(posedge core_clk)
    begin
        if (srst || !operating_enable_bit)
        begin
            motion_active_r <= 1'b0;
            rotate_allowed_r <= 1'b0;
        end
        else if (smp_valid)
        begin
            motion_active_r <= |mot_hit;
            rotate_allowed_r <= |tilt_hit;
        end
    end
endmodule // tmt_tap_cfg

// ### tmt_tap_cfg_assertions.sv
`timescale 1ns/1ps
module tmt_tap_cfg_assertions (
    // Clock and reset
    input wire core_clk,
    input wire srst,
    // Bus pins
    input wire scl_in,
    input wire sda_out,
    input wire sda_oe,
    // Control and samples
    input wire operating_enable_bit,
    input wire smp_valid,
    // Detector outputs
    input wire single_tap_r,
    input wire double_tap_r,
    input wire tap_int_r,
    input wire motion_active_r,
    input wire rotate_allowed_r
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);
    // ================
    // Bus pin checks
    AST_SDA_LOW: assert property (sda_out == 1'b0)
        else $error("sda_out not held low");
    // Ack may only start while the bus clock is low
    AST_ACK_SCL_LOW: assert property ($rose(sda_oe) |-> !scl_in)
        else $error("sda_oe rose with scl high");
    // ================
    // Detector checks
    AST_INT_OR: assert property (tap_int_r == (single_tap_r | double_tap_r))
        else $error("tap_int_r differs from tap pulses");
    AST_SINGLE_PULSE: assert property (single_tap_r |=> !single_tap_r)
        else $error("single tap pulse too long");
    AST_DOUBLE_PULSE: assert property (double_tap_r |=> !double_tap_r)
        else $error("double tap pulse too long");
    AST_TAP_ON_SAMPLE: assert property (tap_int_r |-> $past(smp_valid, 2))
        else $error("tap pulse not two cycles after a sample");
    AST_MOTION_ON_SAMPLE: assert property ($changed(motion_active_r) |->
        $past(smp_valid) || !$past(operating_enable_bit))
        else $error("motion changed without a sample");
    AST_ROTATE_ON_SAMPLE: assert property ($changed(rotate_allowed_r) |->
        $past(smp_valid) || !$past(operating_enable_bit))
        else $error("rotate changed without a sample");
    AST_IDLE_WHEN_OFF: assert property (!operating_enable_bit |=>
        !tap_int_r && !motion_active_r && !rotate_allowed_r)
        else $error("outputs active while disabled");
endmodule // tmt_tap_cfg_assertions
